// *** include/sltpg_regs.svh ***
// Register offsets, field positions, reset values and seeds of the
// serial link test-pattern generator.
// Assumes 12-bit byte addresses and 8-bit register data.
`ifndef SLTPG_REGS_SVH
`define SLTPG_REGS_SVH
`define SLTPG_ADDR_CFG 12'h000
`define SLTPG_ADDR_UP_FIRST 12'h551
`define SLTPG_ADDR_UP_LAST 12'h558
`define SLTPG_ADDR_LNK 12'h572
`define SLTPG_ADDR_ITC 12'h573
`define SLTPG_ADDR_LTC 12'h574
`define SLTPG_ADDR_STAT 12'h575
`define SLTPG_CFG_SRST_BIT 0
`define SLTPG_ITC_CODE_MSB 3
`define SLTPG_ITC_CODE_LSB 0
`define SLTPG_ITC_PT_MSB 5
`define SLTPG_ITC_PT_LSB 4
`define SLTPG_LTC_SEL_MSB 2
`define SLTPG_LTC_SEL_LSB 0
`define SLTPG_LNK_IGN_MSB 7
`define SLTPG_LNK_IGN_LSB 6
`define SLTPG_ITC_RST 8'h00
`define SLTPG_LTC_RST 8'h00
`define SLTPG_LNK_RST 8'h00
`define SLTPG_UP_RST 64'h0
`define SLTPG_SEED_PN31 31'h0003afff
`define SLTPG_SEED_PN23 31'h00003aff
`define SLTPG_SEED_PN15 31'h000003af
`define SLTPG_SEED_PN9 31'h00000092
`define SLTPG_SEED_PN7 31'h00000007
`define SLTPG_SMP_W 16
`define SLTPG_SYM_W 10
`define SLTPG_OCT_W 8
`endif

// *** include/sltpg_pkg.sv ***
// Types of the serial link test-pattern generator.
// Assumes the constants of sltpg_regs.svh.
package sltpg_pkg;
	typedef enum logic [3:0]
	{
		SLTPG_OFF = 4'h0,
		SLTPG_CHK = 4'h1,
		SLTPG_TOG = 4'h2,
		SLTPG_PN31 = 4'h3,
		SLTPG_PN23 = 4'h4,
		SLTPG_PN15 = 4'h5,
		SLTPG_PN9 = 4'h6,
		SLTPG_PN7 = 4'h7,
		SLTPG_RAMP = 4'h8,
		SLTPG_UREP = 4'he,
		SLTPG_USGL = 4'hf
	} sltpg_code_t;

	typedef enum logic [1:0]
	{
		SLTPG_PT_SMP = 2'b00,
		SLTPG_PT_SYM = 2'b01,
		SLTPG_PT_OCT = 2'b10,
		SLTPG_PT_NONE = 2'b11
	} sltpg_pt_t;

	typedef struct packed
	{
		logic [7:0] itc;
		logic [7:0] ltc;
		logic [7:0] lnk;
		logic [7:0] rdata;
		logic [63:0] up;
		logic [30:0] lfsr;
		logic [15:0] ramp;
		logic [1:0] uidx;
		logic udone;
		logic phase;
		logic fresh;
		logic [5:0] cfg_last;
		logic [15:0] smp;
		logic [9:0] sym;
		logic [7:0] oct;
		logic [2:0] sy;
		logic sync_ok;
		logic sync_out_n;
	} sltpg_st_t;
endpackage

// *** hdl/sltpg_top.sv ***
// Test-pattern generator for a multi-lane serial converter link.
// Assumes step strobes and data from link logic on clk_sys; the sync
// request pin is asynchronous.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "sltpg_regs.svh"

// How it works
// - Low nibble of interface test control picks pattern; zero passes data.
// - Bits five to four of interface test control pick injection point.
// - Point 00 sample, 01 ten-bit symbol, 10 eight-bit octet input.
// - Code 1 checkerboard 5555/aaaa, code 2 zero/one words, truncated.
// - Codes 3 to 7 give PRBS 31, 23, 15, 9, 7 with fixed seeds.
// - Code 8 ramps, wrapping at the injection word width.
// - Code 14 repeats the four user words forever.
// - Code 15 sends the four user words once, then zeros.
// - User words come from the user pattern registers.
// - At sample input all samples of a frame share one word.
// - Sample-input PRBS9 starts 496f, c9a9; PRBS23 starts ff5c, 0029.
// - Symbol input gives one ten-bit symbol per step, upper word bits.
// - Octet input gives one octet per step, upper word bits.
// - Link test register bits two to zero select link-layer patterns.
module sltpg_top
(
	input wire logic clk_sys, // 25 MHz system clock
	input wire logic rst_n, // Asynchronous reset
	input wire logic [11:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [7:0] reg_rdata, // Read data, cycle after strobe
	input wire logic [15:0] smp_in, // Frame sample word
	input wire logic smp_step, // New frame
	input wire logic [9:0] sym_in, // Ten-bit symbol
	input wire logic sym_step, // New symbol
	input wire logic [7:0] oct_in, // Octet to scrambler
	input wire logic oct_step, // New octet
	output logic [15:0] smp_out, // Sample word to transport
	output logic [9:0] sym_out, // Symbol to physical layer
	output logic [7:0] oct_out, // Octet to scrambler
	output logic [2:0] dll_test_sel, // Link-layer test select
	input wire logic link_sync_request_n, // Sync request pin
	output logic link_sync_request_out_n // Filtered sync request
);
	sltpg_pkg::sltpg_st_t q;
	sltpg_pkg::sltpg_st_t n;

	// ------------------------------------------------------------
	// Pattern helpers
	// ------------------------------------------------------------
	// Seed bit 0 goes out first, so the seed is loaded bit-reversed
	function automatic logic [30:0] seed_of(input logic [3:0] c);
		logic [30:0] raw;
		int l;
		raw = 31'h0;
		l = len_of(c);
		unique case (c)
			sltpg_pkg::SLTPG_PN31: raw = `SLTPG_SEED_PN31;
			sltpg_pkg::SLTPG_PN23: raw = `SLTPG_SEED_PN23;
			sltpg_pkg::SLTPG_PN15: raw = `SLTPG_SEED_PN15;
			sltpg_pkg::SLTPG_PN9: raw = `SLTPG_SEED_PN9;
			sltpg_pkg::SLTPG_PN7: raw = `SLTPG_SEED_PN7;
			default: raw = 31'h0;
		endcase
		seed_of = 31'h0;
		for (int i = 0; i < 31; i++)
		begin
			if (i < l)
				seed_of[l - 1 - i] = raw[i];
		end
	endfunction

	function automatic int len_of(input logic [3:0] c);
		unique case (c)
			sltpg_pkg::SLTPG_PN31: len_of = 31;
			sltpg_pkg::SLTPG_PN23: len_of = 23;
			sltpg_pkg::SLTPG_PN15: len_of = 15;
			sltpg_pkg::SLTPG_PN9: len_of = 9;
			default: len_of = 7;
		endcase
	endfunction

	// Oldest bit leaves first; feedback enters at the bottom
	function automatic logic [30:0] prbs_next(input logic [30:0] s,
		input logic [3:0] c);
		logic fb;
		logic [31:0] m;
		fb = 1'b0;
		unique case (c)
			sltpg_pkg::SLTPG_PN31: fb = s[30] ^ s[27];
			sltpg_pkg::SLTPG_PN23: fb = s[22] ^ s[17];
			sltpg_pkg::SLTPG_PN15: fb = s[14] ^ s[13];
			sltpg_pkg::SLTPG_PN9: fb = s[8] ^ s[4];
			default: fb = s[6] ^ s[5];
		endcase
		m = (32'h1 << len_of(c)) - 32'h1;
		prbs_next = {s[29:0], fb} & m[30:0];
	endfunction

	function automatic int width_of(input logic [1:0] p);
		unique case (p)
			sltpg_pkg::SLTPG_PT_SMP: width_of = `SLTPG_SMP_W;
			sltpg_pkg::SLTPG_PT_SYM: width_of = `SLTPG_SYM_W;
			default: width_of = `SLTPG_OCT_W;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic [3:0] code;
	logic [1:0] pt;
	logic reload;
	logic step;

	assign code = q.itc[`SLTPG_ITC_CODE_MSB:`SLTPG_ITC_CODE_LSB];
	assign pt = q.itc[`SLTPG_ITC_PT_MSB:`SLTPG_ITC_PT_LSB];
	assign reload = (q.itc[5:0] != q.cfg_last);

	always_comb
	begin
		logic [30:0] s;
		logic [15:0] w;
		logic [2:0] ui;
		int wd;
		n = q;
		s = q.lfsr;
		w = 16'h0;
		ui = 3'(reg_addr - `SLTPG_ADDR_UP_FIRST);
		wd = width_of(pt);
		n.rdata = 8'h00;
		if (reg_wr)
		begin
			if (reg_addr == `SLTPG_ADDR_CFG)
			begin
				// Self-clearing soft reset returns to normal data
				if (reg_wdata[`SLTPG_CFG_SRST_BIT])
				begin
					n.itc = `SLTPG_ITC_RST;
					n.ltc = `SLTPG_LTC_RST;
					n.lnk = `SLTPG_LNK_RST;
				end
			end
			else if (reg_addr >= `SLTPG_ADDR_UP_FIRST &&
				reg_addr <= `SLTPG_ADDR_UP_LAST)
				n.up[{ui, 3'b000} +: 8] = reg_wdata;
			else if (reg_addr == `SLTPG_ADDR_LNK)
				n.lnk = reg_wdata;
			else if (reg_addr == `SLTPG_ADDR_ITC)
				n.itc = reg_wdata;
			else if (reg_addr == `SLTPG_ADDR_LTC)
				n.ltc = {5'h00, reg_wdata[2:0]};
		end
		if (reg_rd)
		begin
			if (reg_addr >= `SLTPG_ADDR_UP_FIRST &&
				reg_addr <= `SLTPG_ADDR_UP_LAST)
				n.rdata = q.up[{ui, 3'b000} +: 8];
			else if (reg_addr == `SLTPG_ADDR_LNK)
				n.rdata = q.lnk;
			else if (reg_addr == `SLTPG_ADDR_ITC)
				n.rdata = q.itc;
			else if (reg_addr == `SLTPG_ADDR_LTC)
				n.rdata = q.ltc;
			else if (reg_addr == `SLTPG_ADDR_STAT)
				n.rdata = {3'h0, q.fresh, q.udone, q.phase, q.uidx};
		end

		// Step strobe of the chosen injection point
		unique case (pt)
			sltpg_pkg::SLTPG_PT_SMP: step = smp_step;
			sltpg_pkg::SLTPG_PT_SYM: step = sym_step;
			sltpg_pkg::SLTPG_PT_OCT: step = oct_step;
			default: step = 1'b0;
		endcase

		// Words are built MSB-aligned, narrower points take the top bits
		unique case (code)
			sltpg_pkg::SLTPG_CHK: w = q.phase ? 16'haaaa : 16'h5555;
			sltpg_pkg::SLTPG_TOG: w = q.phase ? 16'hffff : 16'h0000;
			sltpg_pkg::SLTPG_PN31, sltpg_pkg::SLTPG_PN23,
			sltpg_pkg::SLTPG_PN15, sltpg_pkg::SLTPG_PN9,
			sltpg_pkg::SLTPG_PN7:
			begin
				for (int i = 0; i < 16; i++)
				begin
					if (i < wd)
					begin
						w[15 - i] = s[len_of(code) - 1];
						s = prbs_next(s, code);
					end
				end
			end
			sltpg_pkg::SLTPG_RAMP: w = 16'(q.ramp << (16 - wd));
			sltpg_pkg::SLTPG_UREP: w = q.up[{q.uidx, 4'h0} +: 16];
			sltpg_pkg::SLTPG_USGL:
				w = q.udone ? 16'h0 : q.up[{q.uidx, 4'h0} +: 16];
			default: w = 16'h0;
		endcase

		if (reload)
		begin
			n.cfg_last = q.itc[5:0];
			n.lfsr = seed_of(code);
			n.ramp = 16'h0;
			n.uidx = 2'd0;
			n.udone = 1'b0;
			n.phase = 1'b0;
			n.fresh = 1'b1;
		end
		else if (step && code != sltpg_pkg::SLTPG_OFF)
		begin
			n.lfsr = s;
			n.ramp = q.ramp + 16'h1;
			n.phase = ~q.phase;
			n.uidx = q.uidx + 2'd1;
			if (q.uidx == 2'd3 && code == sltpg_pkg::SLTPG_USGL)
				n.udone = 1'b1;
			n.fresh = 1'b0;
		end

		// Injected point takes the pattern, the others pass data
		if (smp_step)
		begin
			if (!reload && code != sltpg_pkg::SLTPG_OFF &&
				pt == sltpg_pkg::SLTPG_PT_SMP)
				n.smp = w;
			else
				n.smp = smp_in;
		end
		if (sym_step)
		begin
			if (!reload && code != sltpg_pkg::SLTPG_OFF &&
				pt == sltpg_pkg::SLTPG_PT_SYM)
				n.sym = w[15:6];
			else
				n.sym = sym_in;
		end
		if (oct_step)
		begin
			if (!reload && code != sltpg_pkg::SLTPG_OFF &&
				pt == sltpg_pkg::SLTPG_PT_OCT)
				n.oct = w[15:8];
			else
				n.oct = oct_in;
		end

		// Three-stage sync; a change counts once stages two and three agree
		n.sy = {q.sy[1:0], link_sync_request_n};
		if (q.sy[1] == q.sy[2])
			n.sync_ok = q.sy[2];
		// Ignore bits let link-layer tests run without resync
		n.sync_out_n = (q.lnk[`SLTPG_LNK_IGN_MSB:`SLTPG_LNK_IGN_LSB] == 2'b11)
			? 1'b1 : n.sync_ok;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.sy <= 3'b111;
			q.sync_ok <= 1'b1;
			q.sync_out_n <= 1'b1;
		end
		else
			q <= n;
	end

	assign reg_rdata = q.rdata;
	assign smp_out = q.smp;
	assign sym_out = q.sym;
	assign oct_out = q.oct;
	assign dll_test_sel = q.ltc[`SLTPG_LTC_SEL_MSB:`SLTPG_LTC_SEL_LSB];
	assign link_sync_request_out_n = q.sync_out_n;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	property p_off_pass;
		(code == 4'h0 && smp_step) |=> (smp_out == $past(smp_in));
	endproperty
	a_off_pass: assert property (p_off_pass)
		else $error("Normal sample data not passed");

	property p_other_point_pass;
		(pt == 2'b01 && smp_step) |=> (smp_out == $past(smp_in));
	endproperty
	a_other_point_pass: assert property (p_other_point_pass)
		else $error("Sample path altered at symbol injection");

	property p_chk_alt;
		(code == 4'h1 && pt == 2'b00 && smp_step && !reload && !q.fresh)
			|=> (smp_out == ~$past(smp_out));
	endproperty
	a_chk_alt: assert property (p_chk_alt)
		else $error("Checkerboard did not alternate");

	property p_pn9_first;
		(code == 4'h6 && pt == 2'b00 && q.fresh && smp_step && !reload)
			|=> (smp_out == 16'h496f);
	endproperty
	a_pn9_first: assert property (p_pn9_first)
		else $error("First PRBS9 frame word wrong");

	property p_pn23_first;
		(code == 4'h4 && pt == 2'b00 && q.fresh && smp_step && !reload)
			|=> (smp_out == 16'hff5c);
	endproperty
	a_pn23_first: assert property (p_pn23_first)
		else $error("First PRBS23 frame word wrong");

	property p_ramp_oct;
		(code == 4'h8 && pt == 2'b10 && oct_step && !reload && !q.fresh)
			|=> (oct_out == 8'($past(oct_out) + 8'h1));
	endproperty
	a_ramp_oct: assert property (p_ramp_oct)
		else $error("Octet ramp did not step by one");

	property p_user_first;
		(code == 4'he && pt == 2'b00 && q.uidx == 2'd0 && smp_step &&
			!reload) |=> (smp_out == $past(q.up[15:0]));
	endproperty
	a_user_first: assert property (p_user_first)
		else $error("Repeat mode did not send first user word");

	property p_single_zero;
		(code == 4'hf && pt == 2'b00 && q.udone && smp_step && !reload)
			|=> (smp_out == 16'h0000);
	endproperty
	a_single_zero: assert property (p_single_zero)
		else $error("Single mode did not end in zeros");

	property p_sym_chk;
		(code == 4'h1 && pt == 2'b01 && sym_step && !reload)
			|=> (sym_out == 10'h155 || sym_out == 10'h2aa);
	endproperty
	a_sym_chk: assert property (p_sym_chk)
		else $error("Symbol checkerboard value wrong");

	property p_frame_hold;
		(!smp_step) |=> $stable(smp_out);
	endproperty
	a_frame_hold: assert property (p_frame_hold)
		else $error("Sample word changed inside a frame");

	property p_ltc_write;
		(reg_wr && reg_addr == 12'h574) |=>
			(dll_test_sel == $past(reg_wdata[2:0]));
	endproperty
	a_ltc_write: assert property (p_ltc_write)
		else $error("Link test select not written");

	property p_soft_reset;
		(reg_wr && reg_addr == 12'h000 && reg_wdata[0]) |=>
			(q.itc == 8'h00) ##1 (q.fresh || code == 4'h0);
	endproperty
	a_soft_reset: assert property (p_soft_reset)
		else $error("Soft reset did not clear test mode");

	property p_reseed;
		reload |=> (q.fresh && q.lfsr == seed_of(code));
	endproperty
	a_reseed: assert property (p_reseed)
		else $error("Generator not reseeded on change");

	c_pn9: cover property (code == 4'h6 && smp_step ##1 smp_step);
	c_single_done: cover property (code == 4'hf && q.udone);
	c_oct_ramp: cover property (code == 4'h8 && pt == 2'b10 && oct_step);
	c_sync_ignored: cover property (q.lnk == 8'hc0 && !q.sync_ok);
endmodule

// *** tb/sltpg_rx.sv ***
// Far-end receiver model: takes each injected word and drives sync request.
// Assumes the generator's step strobes and outputs on clk_sys.
`timescale 1ns/1ps
module sltpg_rx
(
	input wire logic clk_sys, // System clock
	input wire logic rst_n, // Asynchronous reset
	input wire logic [2:0] steps, // Step strobes: oct, sym, smp
	input wire logic [15:0] smp_out, // Sample word
	input wire logic [9:0] sym_out, // Symbol
	input wire logic [7:0] oct_out, // Octet
	input wire logic want_sync, // Receiver asks for resync
	output logic link_sync_request_n, // Sync request pin
	output logic [15:0] got_smp, // Last sample taken
	output logic [9:0] got_sym, // Last symbol taken
	output logic [7:0] got_oct // Last octet taken
);
	logic [2:0] stp_q;

	// Idle high: no request while in reset
	assign link_sync_request_n = !(want_sync && rst_n);

	// Words land one cycle after their step, so take them then
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stp_q <= 3'h0;
			got_smp <= 16'h0000;
			got_sym <= 10'h000;
			got_oct <= 8'h00;
		end
		else
		begin
			stp_q <= steps;
			if (stp_q[0])
				got_smp <= smp_out;
			if (stp_q[1])
				got_sym <= sym_out;
			if (stp_q[2])
				got_oct <= oct_out;
		end
	end
endmodule

// *** tb/sltpg_tb.sv ***
// Self-checking bench of the serial link test-pattern generator.
// Assumes sltpg_top, the receiver model sltpg_rx and the register header.
`timescale 1ns/1ps
`include "sltpg_regs.svh"
`define CHK(nm, e, g) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			$display("BAD %s exp %h got %h", nm, e, g); \
			err_count++; \
		end \
	end
module serial_link_test_pattern_gen_test;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [2:0] steps = 3'h0;
	logic [15:0] smp_out, got_smp;
	logic [9:0] sym_out, got_sym;
	logic [7:0] oct_out, got_oct;
	logic [2:0] dll_test_sel;
	logic sync_n, sync_out_n;
	logic want_sync = 1'b0;
	int err_count = 0;
	int total_checks = 0;
	localparam logic [15:0] NRM = 16'h9e37;
	logic [15:0] up [4] = '{16'hfff0, 16'h8041, 16'h0ffc, 16'h5a5f};
	logic [3:0] cl [11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
		4'h8, 4'h9, 4'he, 4'hf};
	int ns [5] = '{31, 23, 15, 9, 7};
	int ks [5] = '{28, 18, 14, 5, 6};
	logic [30:0] sds [5] = '{31'h0003afff, 31'h3aff, 31'h3af, 31'h92, 31'h7};

	sltpg_top uut
	(
		.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .smp_in(NRM), .smp_step(steps[0]),
		.sym_in(NRM[15:6]), .sym_step(steps[1]), .oct_in(NRM[15:8]),
		.oct_step(steps[2]), .smp_out(smp_out), .sym_out(sym_out),
		.oct_out(oct_out), .dll_test_sel(dll_test_sel),
		.link_sync_request_n(sync_n), .link_sync_request_out_n(sync_out_n)
	);

	sltpg_rx rx
	(
		.clk_sys(clk_sys), .rst_n(rst_n), .steps(steps),
		.smp_out(smp_out), .sym_out(sym_out), .oct_out(oct_out),
		.want_sync(want_sync), .link_sync_request_n(sync_n),
		.got_smp(got_smp), .got_sym(got_sym), .got_oct(got_oct)
	);

	initial
	begin
		forever #20 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------
	// Bus and stream helpers
	// ------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		`CHK("rdata", e, reg_rdata)
	endtask

	// Word expected at step i, MSB-aligned; PRBS bits leave seed LSB first
	function automatic logic [15:0] expw(input logic [3:0] c,
		input logic [1:0] pt, input int i);
		int w;
		logic [127:0] b;
		logic [15:0] r;
		w = (pt == 2'b00) ? 16 : (pt == 2'b01) ? 10 : 8;
		case (c)
		4'h0: r = NRM;
		4'h1: r = i[0] ? 16'haaaa : 16'h5555;
		4'h2: r = i[0] ? 16'hffff : 16'h0000;
		4'h8: r = 16'(i % (1 << w)) << (16 - w);
		4'he: r = up[i % 4];
		4'hf: r = (i < 4) ? up[i] : 16'h0000;
		default: r = 16'h0000;
		endcase
		if (c >= 4'h3 && c <= 4'h7)
		begin
			for (int j = 0; j < 128; j++)
				b[j] = (j < ns[c - 3]) ? sds[c - 3][j] :
					b[j - ns[c - 3]] ^ b[j - ks[c - 3]];
			for (int t = 0; t < w; t++)
				r[15 - t] = b[i * w + t];
		end
		return r;
	endfunction

	task automatic step(input logic [1:0] pt, input logic [15:0] e);
		@(posedge clk_sys);
		steps <= 3'h7;
		@(posedge clk_sys);
		steps <= 3'h0;
		@(posedge clk_sys);
		#1;
		`CHK("smp", (pt == 2'b00) ? e : NRM, got_smp)
		`CHK("sym", (pt == 2'b01) ? e[15:6] : NRM[15:6], got_sym)
		`CHK("oct", (pt == 2'b10) ? e[15:8] : NRM[15:8], got_oct)
	endtask

	task automatic run(input logic [3:0] c, input logic [1:0] pt, input int n);
		wr(`SLTPG_ADDR_ITC, {2'b00, pt, c});
		repeat (2) @(posedge clk_sys);
		for (int i = 0; i < n; i++)
			step(pt, expw(c, pt, i));
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		rd(`SLTPG_ADDR_ITC, 8'h00);
		rd(`SLTPG_ADDR_LTC, 8'h00);
		wr(12'h7ff, 8'h5a);
		rd(12'h7ff, 8'h00);
		wr(`SLTPG_ADDR_ITC, 8'h26);
		rd(`SLTPG_ADDR_ITC, 8'h26);
		for (int v = 0; v < 8; v++)
		begin
			wr(`SLTPG_ADDR_LTC, 8'(v));
			@(posedge clk_sys);
			#1;
			`CHK("dll_sel", 3'(v), dll_test_sel)
		end
		$display("test regs done");
	endtask

	task automatic t_pat();
		for (int k = 0; k < 4; k++)
		begin
			wr(12'h551 + 12'(2 * k), up[k][7:0]);
			wr(12'h552 + 12'(2 * k), up[k][15:8]);
		end
		rd(12'h558, up[3][15:8]);
		for (int p = 0; p < 3; p++)
			for (int j = 0; j < 11; j++)
				run(cl[j], 2'(p), 6);
		run(4'h1, 2'b11, 2);
		$display("test patterns done");
	endtask

	task automatic t_wrap();
		run(4'h8, 2'b10, 258);
		$display("test ramp wrap done");
	endtask

	// Leaving test mode goes through the soft reset
	task automatic t_srst();
		wr(`SLTPG_ADDR_LNK, 8'hc0);
		wr(`SLTPG_ADDR_CFG, 8'h81);
		rd(`SLTPG_ADDR_ITC, 8'h00);
		rd(`SLTPG_ADDR_LNK, 8'h00);
		rd(`SLTPG_ADDR_CFG, 8'h00);
		run(4'h0, 2'b00, 2);
		$display("test soft reset done");
	endtask

	task automatic t_sync();
		want_sync <= 1'b1;
		repeat (10) @(posedge clk_sys);
		#1;
		`CHK("sync_out", 1'b0, sync_out_n)
		wr(`SLTPG_ADDR_LNK, 8'hc0);
		repeat (10) @(posedge clk_sys);
		#1;
		`CHK("sync_out", 1'b1, sync_out_n)
		want_sync <= 1'b0;
		wr(`SLTPG_ADDR_CFG, 8'h81);
		$display("test sync ignore done");
	endtask

	// Back-to-back frames: one PRBS word per consecutive step
	task automatic t_burst();
		wr(`SLTPG_ADDR_ITC, 8'h06);
		repeat (2) @(posedge clk_sys);
		@(posedge clk_sys);
		steps <= 3'h1;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk_sys);
			if (i == 2)
				steps <= 3'h0;
			#1;
			`CHK("burst", expw(4'h6, 2'b00, i), smp_out)
		end
		@(posedge clk_sys);
		$display("test burst done");
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Whole run is near 1600 cycles; this leaves ample margin
	initial
	begin
		#400000;
		err_count++;
		report_and_stop();
	end

	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_regs();
		t_pat();
		t_burst();
		t_wrap();
		t_srst();
		t_sync();
		report_and_stop();
	end
endmodule
